// [src/patc_prox_timing.sv]
// Proximity converter recovery and gain configuration with timing sequencer
//
// Notes on behaviour
// - Recovery code picks 1..511 converter clocks
// - Recovery clock 50 ns, scaled by 2^gain
// - Recovery register resets to 0x70
// - Gain scales LED pulse and integration
// - Gain divides converter clock by 2^gain
//
// Decided for this implementation: the strobed register port.
`default_nettype none
module patc_prox_timing (
    input  wire logic                          clock,          // 50 MHz clock
    input  wire logic                          rstn,           // Synchronous reset, active low
    input  wire patc_pkg::patc_req_t           busReq,         // Register port request
    output var  logic [patc_pkg::DATA_W-1:0]   rdData_q,       // Read data, cycle after read strobe
    input  wire logic                          convStart,      // Start one proximity measurement
    output var  logic                          busy_q,         // Measurement in progress
    output var  logic                          recovering_q,   // Recovery period running
    output var  logic                          ledOn_q,        // LED pulse and integration window
    output var  logic                          adcTick_q,      // Divided converter clock tick
    output var  logic                          done_q,         // One-cycle end of measurement
    output var  logic [2:0]                    gainActive_q    // Gain exponent of current measurement
);
    // Recovery length in converter clocks for each code
    function automatic logic [15:0] recoveryClocks(input logic [2:0] code);
        logic [15:0] n;
        n = 16'h0001;
        case (code)
            3'd0:    n = 16'h0001;
            3'd1:    n = 16'h0007;
            3'd2:    n = 16'h000F;
            3'd3:    n = 16'h001F;
            3'd4:    n = 16'h003F;
            3'd5:    n = 16'h007F;
            3'd6:    n = 16'h00FF;
            3'd7:    n = 16'h01FF;
            default: n = 16'h0001;
        endcase
        return n;
    endfunction

    // Divided converter clock period in ns
    function automatic logic [12:0] adcPeriodNs(input logic [2:0] gain);
        return 13'(patc_pkg::ADC_CLK_NS) << gain;
    endfunction

    // Software-visible fields
    logic [2:0]  recCode_q;     // recovery_code field
    logic [2:0]  gainExp_q;     // prox_gain_exponent field
    // Sequencer state
    patc_pkg::patc_state_t state_q;
    patc_pkg::patc_state_t state_d;
    logic [2:0]  recLatched_q;  // Recovery code captured at start
    logic [patc_pkg::ACC_W-1:0] acc_q;   // Phase accumulator in ns
    logic [patc_pkg::ACC_W-1:0] acc_d;
    logic [patc_pkg::CNT_W-1:0] cnt_q;   // Remaining converter clocks
    logic [patc_pkg::CNT_W-1:0] cnt_d;

    // Register decode
    wire hitRec   = busReq.addr == patc_pkg::REC_OFS;
    wire hitGain  = busReq.addr == patc_pkg::GAIN_OFS;
    wire wrRec    = busReq.wrEn && hitRec;
    wire wrGain   = busReq.wrEn && hitGain;
    // Read views, reserved bits forced to zero
    wire [7:0] recView  = {1'b0, recCode_q, 4'h0};
    wire [7:0] gainView = {5'h00, gainExp_q};
    wire [7:0] rdMux    = hitRec ? recView : (hitGain ? gainView : 8'h00);

    // Sequencer decode
    wire        idle      = state_q == patc_pkg::SEQ_IDLE;
    wire        startNow  = idle && convStart;
    wire [patc_pkg::ACC_W-1:0] period  = adcPeriodNs(gainActive_q);
    wire [patc_pkg::ACC_W-1:0] accNext = acc_q + patc_pkg::CLK_STEP_NS;
    wire        tickNow   = !idle && (accNext >= period);
    wire        lastClk   = tickNow && (cnt_q == 16'h0001);
    // Fixed count of divided clocks: the divided period alone stretches the window by 2^gain
    wire [patc_pkg::CNT_W-1:0] integLen = patc_pkg::INTEG_BASE_CLKS;

    // Register writes: only the defined fields are stored
    always_ff @(posedge clock) begin
        if (!rstn) begin
            recCode_q <= patc_pkg::REC_RESET[patc_pkg::REC_MSB:patc_pkg::REC_LSB];
            gainExp_q <= patc_pkg::GAIN_RESET[patc_pkg::GAIN_MSB:patc_pkg::GAIN_LSB];
        end else begin
            if (wrRec) begin
                recCode_q <= busReq.wrData[patc_pkg::REC_MSB:patc_pkg::REC_LSB];
            end
            if (wrGain) begin
                gainExp_q <= busReq.wrData[patc_pkg::GAIN_MSB:patc_pkg::GAIN_LSB];
            end
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= busReq.rdEn ? rdMux : 8'h00;
        end
    end

    // Next-state logic of the sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        // Phase accumulator wraps by one divided period on each tick
        acc_d   = tickNow ? (accNext - period) : accNext;
        case (state_q)
            // Wait for a start; accumulator restarts for a fixed phase
            patc_pkg::SEQ_IDLE: begin
                acc_d = '0;
                if (convStart) begin
                    state_d = patc_pkg::SEQ_RECOVER;
                    cnt_d   = recoveryClocks(recCode_q);
                end
            end
            // Count recovery converter clocks at the divided rate
            patc_pkg::SEQ_RECOVER: begin
                if (tickNow) begin
                    cnt_d = cnt_q - 16'h0001;
                end
                if (lastClk) begin
                    state_d = patc_pkg::SEQ_INTEG;
                    cnt_d   = integLen;
                end
            end
            // LED pulse and integration, stretched by the gain
            patc_pkg::SEQ_INTEG: begin
                if (tickNow) begin
                    cnt_d = cnt_q - 16'h0001;
                end
                if (lastClk) begin
                    state_d = patc_pkg::SEQ_IDLE;
                end
            end
            default: begin
                state_d = patc_pkg::SEQ_IDLE;
                acc_d   = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q <= patc_pkg::SEQ_IDLE;
            acc_q   <= '0;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            acc_q   <= acc_d;
            cnt_q   <= cnt_d;
        end
    end

    // Settings snapshot: a write during a measurement waits for the next one
    always_ff @(posedge clock) begin
        if (!rstn) begin
            gainActive_q <= 3'd0;
            recLatched_q <= 3'd7;
        end else if (startNow) begin
            gainActive_q <= gainExp_q;
            recLatched_q <= recCode_q;
        end
    end

    // Registered status outputs
    always_ff @(posedge clock) begin
        if (!rstn) begin
            busy_q       <= 1'b0;
            recovering_q <= 1'b0;
            ledOn_q      <= 1'b0;
            adcTick_q    <= 1'b0;
            done_q       <= 1'b0;
        end else begin
            busy_q       <= state_d != patc_pkg::SEQ_IDLE;
            recovering_q <= state_d == patc_pkg::SEQ_RECOVER;
            ledOn_q      <= state_d == patc_pkg::SEQ_INTEG;
            adcTick_q    <= tickNow;
            done_q       <= (state_q == patc_pkg::SEQ_INTEG) && lastClk;
        end
    end

    // Checking helpers: cycles since last tick, ticks per phase
    logic [patc_pkg::GAP_W-1:0] gapCnt_q;
    logic [patc_pkg::CNT_W-1:0] recTicks_q;
    logic [patc_pkg::CNT_W-1:0] intTicks_q;
    wire  [patc_pkg::GAP_W-1:0] gapNow = gapCnt_q + 9'd1;
    wire  [patc_pkg::ACC_W-1:0] gapMin = period / patc_pkg::CLK_STEP_NS;
    wire  [patc_pkg::ACC_W-1:0] gapMax = (period + patc_pkg::CLK_STEP_NS - 13'd1) / patc_pkg::CLK_STEP_NS;

    // Helper counters restart with each measurement
    always_ff @(posedge clock) begin
        if (!rstn || startNow) begin
            gapCnt_q   <= '0;
            recTicks_q <= '0;
            intTicks_q <= '0;
        end else begin
            gapCnt_q   <= tickNow ? 9'd0 : gapNow;
            if (tickNow && state_q == patc_pkg::SEQ_RECOVER) begin
                recTicks_q <= recTicks_q + 16'h0001;
            end
            if (tickNow && state_q == patc_pkg::SEQ_INTEG) begin
                intTicks_q <= intTicks_q + 16'h0001;
            end
        end
    end

    // Recovery field comes out of reset at code 111
    resetRec_a: assert property (@(posedge clock)
        !rstn |=> (recCode_q == 3'd7) && (recView == 8'h70))
        else $error("recovery register not 0x70 after reset");

    // Reserved bits read back as zero
    rsvdRead_a: assert property (@(posedge clock) disable iff (!rstn)
        busReq.rdEn && hitRec |=> (rdData_q[7] == 1'b0) && (rdData_q[3:0] == 4'h0))
        else $error("reserved recovery bits read nonzero");

    // Gain write keeps only the exponent bits
    gainWrite_a: assert property (@(posedge clock) disable iff (!rstn)
        busReq.wrEn && hitGain ##1 busReq.rdEn && hitGain |=> rdData_q == {5'h00, $past(busReq.wrData[2:0], 2)})
        else $error("gain readback differs from written exponent");

    // Recovery phase lasts the coded number of converter clocks
    recLength_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == patc_pkg::SEQ_RECOVER) && lastClk |-> recTicks_q + 16'h0001 == recoveryClocks(recLatched_q))
        else $error("recovery length differs from code");

    // Converter clock spacing matches 50 ns times 2^gain
    tickGap_a: assert property (@(posedge clock) disable iff (!rstn)
        tickNow |-> (13'(gapNow) >= gapMin) && (13'(gapNow) <= gapMax))
        else $error("converter clock spacing wrong for gain");

    // Gain 4 divides the converter clock by 16: 800 ns, 40 cycles
    gainFour_a: assert property (@(posedge clock) disable iff (!rstn)
        tickNow && gainActive_q == 3'd4 |-> gapNow == 9'd40)
        else $error("gain 4 clock not divided by 16");

    // LED and integration window lasts a fixed count of divided clocks
    integLength_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == patc_pkg::SEQ_INTEG) && lastClk |-> intTicks_q + 16'h0001 == patc_pkg::INTEG_BASE_CLKS)
        else $error("integration length differs from base count");

    // LED turns on right after recovery
    ledSeq_a: assert property (@(posedge clock) disable iff (!rstn)
        $fell(recovering_q) |-> ledOn_q && busy_q)
        else $error("LED window not following recovery");

    // LED window ends together with busy and the done pulse
    ledEnd_a: assert property (@(posedge clock) disable iff (!rstn)
        $fell(ledOn_q) |-> done_q && !busy_q)
        else $error("LED window end not marked by done");

    // Recovery write stores the code bits
    recStore_a: assert property (@(posedge clock) disable iff (!rstn)
        busReq.wrEn && hitRec |=> recCode_q == $past(busReq.wrData[patc_pkg::REC_MSB:patc_pkg::REC_LSB]))
        else $error("recovery code not stored on write");

    // Gain write stores the exponent bits
    gainStore_a: assert property (@(posedge clock) disable iff (!rstn)
        busReq.wrEn && hitGain |=> gainExp_q == $past(busReq.wrData[patc_pkg::GAIN_MSB:patc_pkg::GAIN_LSB]))
        else $error("gain exponent not stored on write");

    // Recovery write keeps only the code bits on readback
    recReadback_a: assert property (@(posedge clock) disable iff (!rstn)
        busReq.wrEn && hitRec ##1 busReq.rdEn && hitRec |=> rdData_q == {1'b0, $past(busReq.wrData[6:4], 2), 4'h0})
        else $error("recovery readback differs from written code");

    // Settings are captured when a measurement starts
    gainCapture_a: assert property (@(posedge clock) disable iff (!rstn)
        startNow |=> (gainActive_q == $past(gainExp_q)) && (recLatched_q == $past(recCode_q)))
        else $error("settings not captured at start");

    // Gain 5 divides the converter clock by 32: 1600 ns, 80 cycles
    gainFive_a: assert property (@(posedge clock) disable iff (!rstn)
        tickNow && gainActive_q == 3'd5 |-> gapNow == 9'd80)
        else $error("gain 5 clock not divided by 32");

    // Tick output follows each divided converter clock by one cycle
    tickPulse_a: assert property (@(posedge clock) disable iff (!rstn)
        1'b1 |=> adcTick_q == $past(tickNow))
        else $error("tick output not one cycle after divided clock");

    // A start loads the coded recovery count
    recStart_a: assert property (@(posedge clock) disable iff (!rstn)
        startNow |=> recovering_q && busy_q && (cnt_q == recoveryClocks(recLatched_q)))
        else $error("recovery count not loaded at start");

    // LED window only inside a measurement and never during recovery
    ledBusy_a: assert property (@(posedge clock) disable iff (!rstn)
        ledOn_q |-> busy_q && !recovering_q)
        else $error("LED window outside its phase");

    // Main scenarios
    fullMeas_c: cover property (@(posedge clock) disable iff (!rstn) done_q);
    gainFive_c: cover property (@(posedge clock) disable iff (!rstn) ledOn_q && gainActive_q == 3'd5);
    shortRec_c: cover property (@(posedge clock) disable iff (!rstn) $fell(recovering_q) && recLatched_q == 3'd0);
    recWrite_c: cover property (@(posedge clock) disable iff (!rstn) wrRec && busy_q);
endmodule
`default_nettype wire

// [src/patc_pkg.sv]
// Package with register map, field layout and timing constants for the proximity converter timing block
`default_nettype none
package patc_pkg;
    // Register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] REC_OFS  = 8'h0A;   // prox_recovery_period
    localparam logic [7:0] GAIN_OFS = 8'h0B;   // prox_gain_exponent

    // Reset values
    localparam logic [7:0] REC_RESET  = 8'h70;
    localparam logic [7:0] GAIN_RESET = 8'h00;

    // Field positions
    localparam int unsigned REC_LSB  = 4;
    localparam int unsigned REC_MSB  = 6;
    localparam int unsigned GAIN_LSB = 0;
    localparam int unsigned GAIN_MSB = 2;

    // Timing: host clock period and converter clock period at unity gain, in ns
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ADC_CLK_NS    = 50;
    localparam logic [12:0] CLK_STEP_NS   = 13'(CLK_PERIOD_NS);

    // Converter clocks of LED pulse and integration at unity gain
    localparam logic [15:0] INTEG_BASE_CLKS = 16'h0100;

    // Counter widths
    localparam int unsigned ACC_W = 13;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned GAP_W = 9;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;    // Register offset
        logic [DATA_W-1:0] wrData;  // Write data
        logic              wrEn;    // Write strobe
        logic              rdEn;    // Read strobe
    } patc_req_t;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_RECOVER = 2'b01,
        SEQ_INTEG   = 2'b10
    } patc_state_t;
endpackage
`default_nettype wire

// [verif/patc_host_model.sv]
// Host-side model that issues register accesses and collects read data
`default_nettype none
module patc_host_model (
    input  wire logic                        clock,   // Bench clock
    output var  patc_pkg::patc_req_t         busReq,  // Register port request
    input  wire logic [patc_pkg::DATA_W-1:0] rdData   // Read data from block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic                        rdPend = 1'b0;  // A read was taken at the last edge
    logic [patc_pkg::DATA_W-1:0] readQ[$];       // Captured read data, oldest first
    initial busReq = '0;
    // One access per cycle, changed right after the edge
    task automatic issue(input bit wr, input bit rd, input logic [7:0] a, input logic [7:0] d);
        if (wr && a == patc_pkg::GAIN_OFS && d[2:0] > 3'h5) begin
            d[2:0] = 3'h5; // Gain kept at five or below
        end
        @(posedge clock);
        busReq <= '{addr: a, wrData: d, wrEn: wr, rdEn: rd};
    endtask
    // Strobes low, address and data scrambled so nothing stale looks valid
    task automatic idle();
        @(posedge clock);
        busReq <= '{addr: ~busReq.addr, wrData: ~busReq.wrData, wrEn: 1'b0, rdEn: 1'b0};
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clock) rdPend <= busReq.rdEn;
    always @(negedge clock) begin
        if (rdPend === 1'b1) begin
            readQ.push_back(rdData);
        end
    end
endmodule
`default_nettype wire

// [verif/prox_adc_timing_config_bench.sv]
// Self-checking bench for the proximity converter timing block
`default_nettype none
module prox_adc_timing_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clock = 1'b0;      // 50 MHz clock
    logic                rstn = 1'b0;       // Reset, active low
    logic                convStart = 1'b0;  // Measurement start
    patc_pkg::patc_req_t busReq;            // Request from host model
    logic [7:0]          rdData;            // Read data
    logic                busy, recovering, ledOn, adcTick, done;
    logic [2:0]          gainActive;        // Captured gain
    int                  n_errors = 0;      // Mismatches
    int                  total_checks = 0;  // Comparisons made
    integer              seed = 51;         // Fixed random seed
    logic [2:0]          recM = 3'h7;       // Expected recovery field
    logic [2:0]          gainM = 3'h0;      // Expected gain field
    logic [7:0]          expQ[$];           // Expected read bytes

    // Clock generator
    always #10 clock = ~clock;

    patc_prox_timing u_patc_prox_timing (.clock(clock), .rstn(rstn), .busReq(busReq), .rdData_q(rdData),
        .convStart(convStart), .busy_q(busy), .recovering_q(recovering), .ledOn_q(ledOn),
        .adcTick_q(adcTick), .done_q(done), .gainActive_q(gainActive));
    patc_host_model u_patc_host_model (.clock(clock), .busReq(busReq), .rdData(rdData));

    // Expected byte of a read
    function automatic logic [7:0] expRead(logic [7:0] a);
        if (a == patc_pkg::REC_OFS) return {1'b0, recM, 4'h0};
        if (a == patc_pkg::GAIN_OFS) return {5'h00, gainM};
        return 8'h00;
    endfunction
    // Host cycle on which divided converter tick k lands
    function automatic int tickAt(int k, int g);
        return ((patc_pkg::ADC_CLK_NS << g) * k + patc_pkg::CLK_PERIOD_NS - 1) / patc_pkg::CLK_PERIOD_NS;
    endfunction
    // Converter clocks of recovery for a code
    function automatic int recClocks(int c);
        return (c == 0) ? 1 : (8 << (c - 1)) - 1;
    endfunction
    // Compare and count
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read request, expectation queued
    task automatic rd(logic [7:0] a);
        u_patc_host_model.issue(1'b0, 1'b1, a, 8'h00);
        expQ.push_back(expRead(a));
    endtask
    // Write followed at once by a read of the same place
    task automatic wrRd(logic [7:0] a, logic [7:0] d);
        u_patc_host_model.issue(1'b1, 1'b0, a, d);
        if (a == patc_pkg::REC_OFS) recM = d[6:4];
        if (a == patc_pkg::GAIN_OFS) gainM = d[2:0];
        rd(a);
    endtask
    // Idle the port and compare all collected reads
    task automatic drain();
        u_patc_host_model.idle();
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(16'(rdData), 16'h0000);
        while (expQ.size() > 0) check(16'(u_patc_host_model.readQ.pop_front()), 16'(expQ.pop_front()));
        check(16'(u_patc_host_model.readQ.size()), 16'h0000);
    endtask
    // One measurement with a given gain and recovery code
    task automatic measure(int g, int c);
        logic [31:0] r;
        int          n;
        int          i;
        int          recCnt;
        int          ledCnt;
        int          ticks;
        r = $random(seed);
        n = recClocks(c);
        recCnt = 0;
        ledCnt = 0;
        ticks = 0;
        wrRd(patc_pkg::GAIN_OFS, {r[7:3], 3'(g)});
        wrRd(patc_pkg::REC_OFS, {r[8], 3'(c), r[12:9]});
        drain();
        @(posedge clock);
        convStart <= 1'b1;
        for (i = 1; i < 70000; i++) begin
            @(posedge clock);
            if (i == 1) convStart <= 1'b0;
            if (i == 3) convStart <= 1'b1;
            if (i == 4) convStart <= 1'b0;
            #1;
            if (i == 1) check(16'(gainActive), 16'(g));
            if (recovering === 1'b1) recCnt++;
            if (ledOn === 1'b1) ledCnt++;
            if (adcTick === 1'b1) ticks++;
            if (done === 1'b1) break;
        end
        if (i == 70000) begin
            n_errors++;
            report_and_stop();
        end
        check(16'({busy, ledOn}), 16'h0000);
        check(16'(recCnt), 16'(tickAt(n, g)));
        check(16'(ledCnt), 16'(tickAt(n + 256, g) - tickAt(n, g)));
        check(16'(i), 16'(tickAt(n + 256, g) + 1));
        check(16'(ticks), 16'(n + 256));
        @(posedge clock);
        #1;
        check(16'(busy), 16'h0000);
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [7:0]  a;
        logic [7:0]  d;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(patc_pkg::REC_OFS);
        rd(patc_pkg::GAIN_OFS);
        rd(8'h0C);
        drain();
        // Random back-to-back traffic, unmapped places among it
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            a = r[0] ? (r[1] ? patc_pkg::REC_OFS : patc_pkg::GAIN_OFS) : r[15:8];
            d = r[23:16];
            if (d[2:0] > 3'h5) d[2] = 1'b0;
            wrRd(a, d);
        end
        drain();
        for (int c = 0; c < 8; c++) measure(0, c);
        for (int g = 1; g < 6; g++) measure(g, 7 - g);
        report_and_stop();
    end
endmodule
`default_nettype wire
